//--- logic/gpsr_defs.svh
// constants for the port subregister and interrupt request block
// assumes a byte-wide register bus with byte addresses
`ifndef GPSR_DEFS_SVH
`define GPSR_DEFS_SVH
`define GPSR_ADDR_SEL       12'hFD0
`define GPSR_ADDR_CTL       12'hFD1
`define GPSR_ADDR_OUT       12'hFD2
`define GPSR_ADDR_IN        12'hFD3
`define GPSR_ADDR_SERIAL_AND_CONVERTER_IRQ_PENDING      12'hFC0
`define GPSR_ADDR_PORT_A_PIN_IRQ_PENDING      12'hFC3
`define GPSR_SUB_DIR        8'h01
`define GPSR_SUB_ALT        8'h02
`define GPSR_SUB_WAKE       8'h05
`define GPSR_DIR_RST        8'hFF
`define GPSR_ALT_RST        8'h00
`define GPSR_WAKE_RST       8'h00
`define GPSR_IRQ_RST        8'h00
`define GPSR_SERIAL_AND_CONVERTER_IRQ_PENDING_USED      8'h19
`define GPSR_SERIAL_AND_CONVERTER_IRQ_PENDING_RX_BIT    4
`define GPSR_SERIAL_AND_CONVERTER_IRQ_PENDING_TX_BIT    3
`define GPSR_SERIAL_AND_CONVERTER_IRQ_PENDING_ADC_BIT   0
`define GPSR_PIN6_BIT       6
`endif

//--- logic/gpsr_pkg.sv
// types for the port subregister block
// assumes gpsr_defs.svh is included by the modules that need numbers
package gpsr_pkg;
  // bus request carried as one bundle
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } gpsr_bus_t;
  // per-port pin configuration
  typedef struct packed {
    logic [7:0] dir;
    logic [7:0] alt;
    logic [7:0] wake;
  } gpsr_cfg_t;
endpackage

//--- logic/gpsr_wake.sv
// stop-mode wake detector for one 8-bit port
// assumes pins are synchronous to clk_i
`include "gpsr_defs.svh"
module gpsr_wake (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // control
  input  wire logic       stop_i,
  input  wire logic [7:0] wake_en_i,
  input  wire logic [7:0] pin_i,
  // result
  output logic            wake_o
);
  logic [7:0] last_reg;  // pin level one cycle ago
  logic [7:0] last_next;
  logic       wake_reg;  // registered wake pulse
  logic       wake_next;
  logic       primed_reg;  // high once last_reg holds a real pin sample
  logic       primed_next;

  // either edge on an enabled pin during stop raises wake
  // last_reg resets to zero, which need not match idle pins, so the first cycle is ignored
  always_comb begin
    last_next   = pin_i;
    primed_next = 1'b1;
    wake_next   = stop_i && primed_reg && (|((pin_i ^ last_reg) & wake_en_i));
  end

  // registers only
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      last_reg   <= 8'h00;
      wake_reg   <= 1'b0;
      primed_reg <= 1'b0;
    end else begin
      last_reg   <= last_next;
      wake_reg   <= wake_next;
      primed_reg <= primed_next;
    end
  end

  assign wake_o = wake_reg;

  // an edge on a disabled pin never wakes
  property p_wake_masked;
    @(posedge clk_i) disable iff (rst_i)
      (stop_i && ((pin_i ^ last_reg) & wake_en_i) == 8'h00) |=> !wake_o;
  endproperty
  a_wake_masked: assert property (p_wake_masked) else $error("wake from masked pin");
  // an enabled edge wakes next cycle
  property p_wake_fire;
    @(posedge clk_i) disable iff (rst_i)
      (stop_i && primed_reg && ((pin_i ^ last_reg) & wake_en_i) != 8'h00) |=> wake_o;
  endproperty
  a_wake_fire: assert property (p_wake_fire) else $error("enabled edge missed");
endmodule

//--- logic/gpsr_port.sv
// port pin control with indirect subregisters and interrupt request latches
// assumes a synchronous byte register bus and pins sampled on clk_i
// Operation
// - select code 01H reaches direction subregister
// - direction 1 tristates, samples input; resets 1
// - direction 0 drives output data onto pin
// - alternate function overrides direction bit
// - select code 02H reaches alternate enable
// - enable clear is gpio; set gives alternate
// - select code 05H reaches wake enable
// - enabled pin edge in stop wakes
// - disabled pin never wakes; resets 0
// - source request sets its pending bit
// - pending forwarded when enabled, always readable
// - bit7 pin7, bit6 pin6/comparator, 5:0 pins
// - rx bit4, tx bit3, converter bit0
`include "gpsr_defs.svh"
module gpsr_port (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // register bus
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  input  wire logic [11:0] addr_i,
  input  wire logic [7:0]  wdata_i,
  output logic      [7:0]  rdata_o,
  // pins
  input  wire logic [7:0]  pin_i,
  output logic      [7:0]  pin_o,
  output logic      [7:0]  pin_oe_o,
  // alternate function side
  input  wire logic [7:0]  alt_out_i,
  input  wire logic [7:0]  alt_oe_i,
  // interrupt sources
  input  wire logic [7:0]  pin_irq_i,
  input  wire logic        comp_irq_i,
  input  wire logic        rx_irq_i,
  input  wire logic        tx_irq_i,
  input  wire logic        adc_irq_i,
  // interrupt controller and power
  input  wire logic        irq_global_en_i,
  input  wire logic        stop_i,
  output logic             irq_o,
  output logic             wake_o
);
  gpsr_pkg::gpsr_bus_t bus;          // bundled bus request
  gpsr_pkg::gpsr_cfg_t cfg_reg;      // subregister contents
  gpsr_pkg::gpsr_cfg_t cfg_next;
  logic [7:0]          sel_reg;      // subregister select code
  logic [7:0]          sel_next;
  logic [7:0]          out_reg;      // output data register
  logic [7:0]          out_next;
  logic [7:0]          in_reg;       // sampled input data
  logic [7:0]          in_next;
  logic [7:0]          port_a_pin_irq_pending_reg;     // port pending flags
  logic [7:0]          port_a_pin_irq_pending_next;
  logic [7:0]          serial_and_converter_irq_pending_reg;     // serial and converter pending flags
  logic [7:0]          serial_and_converter_irq_pending_next;
  logic [7:0]          rdata_reg;    // registered read data
  logic [7:0]          rdata_next;
  logic                irq_reg;      // forwarded request
  logic                irq_next;

  assign bus = '{wr: wr_i, rd: rd_i, addr: addr_i, wdata: wdata_i};

  // decode an access to a given byte address
  function automatic logic hit(input gpsr_pkg::gpsr_bus_t b, input logic [11:0] a);
    hit = b.addr == a;
  endfunction

  // source requests mapped onto the port pending register
  function automatic logic [7:0] port_a_pin_irq_pending_src(input logic [7:0] p, input logic c);
    port_a_pin_irq_pending_src = p;
    port_a_pin_irq_pending_src[`GPSR_PIN6_BIT] = p[`GPSR_PIN6_BIT] | c;
  endfunction

  // register updates; hardware set wins over a software clear
  always_comb begin
    sel_next  = sel_reg;
    cfg_next  = cfg_reg;
    out_next  = out_reg;
    in_next   = in_reg;
    port_a_pin_irq_pending_next = port_a_pin_irq_pending_reg;
    serial_and_converter_irq_pending_next = serial_and_converter_irq_pending_reg;
    if (bus.wr) begin
      if (hit(bus, `GPSR_ADDR_SEL)) begin
        sel_next = bus.wdata;
      end else if (hit(bus, `GPSR_ADDR_CTL)) begin
        // unknown select codes swallow the write
        if (sel_reg == `GPSR_SUB_DIR) begin
          cfg_next.dir = bus.wdata;
        end else if (sel_reg == `GPSR_SUB_ALT) begin
          cfg_next.alt = bus.wdata;
        end else if (sel_reg == `GPSR_SUB_WAKE) begin
          cfg_next.wake = bus.wdata;
        end
      end else if (hit(bus, `GPSR_ADDR_OUT)) begin
        out_next = bus.wdata;
      end else if (hit(bus, `GPSR_ADDR_PORT_A_PIN_IRQ_PENDING)) begin
        port_a_pin_irq_pending_next = bus.wdata;
      end else if (hit(bus, `GPSR_ADDR_SERIAL_AND_CONVERTER_IRQ_PENDING)) begin
        // reserved bits held at zero whatever is written
        serial_and_converter_irq_pending_next = bus.wdata & `GPSR_SERIAL_AND_CONVERTER_IRQ_PENDING_USED;
      end
    end
    // input pins sampled only where direction is input
    in_next = (pin_i & cfg_reg.dir) | (in_reg & ~cfg_reg.dir);
    port_a_pin_irq_pending_next = port_a_pin_irq_pending_next | port_a_pin_irq_pending_src(pin_irq_i, comp_irq_i);
    serial_and_converter_irq_pending_next[`GPSR_SERIAL_AND_CONVERTER_IRQ_PENDING_RX_BIT]  = serial_and_converter_irq_pending_next[`GPSR_SERIAL_AND_CONVERTER_IRQ_PENDING_RX_BIT] | rx_irq_i;
    serial_and_converter_irq_pending_next[`GPSR_SERIAL_AND_CONVERTER_IRQ_PENDING_TX_BIT]  = serial_and_converter_irq_pending_next[`GPSR_SERIAL_AND_CONVERTER_IRQ_PENDING_TX_BIT] | tx_irq_i;
    serial_and_converter_irq_pending_next[`GPSR_SERIAL_AND_CONVERTER_IRQ_PENDING_ADC_BIT] = serial_and_converter_irq_pending_next[`GPSR_SERIAL_AND_CONVERTER_IRQ_PENDING_ADC_BIT] | adc_irq_i;
  end

  // read mux and forwarding
  always_comb begin
    rdata_next = 8'h00;
    if (bus.rd) begin
      if (hit(bus, `GPSR_ADDR_SEL)) begin
        rdata_next = sel_reg;
      end else if (hit(bus, `GPSR_ADDR_CTL)) begin
        if (sel_reg == `GPSR_SUB_DIR) begin
          rdata_next = cfg_reg.dir;
        end else if (sel_reg == `GPSR_SUB_ALT) begin
          rdata_next = cfg_reg.alt;
        end else if (sel_reg == `GPSR_SUB_WAKE) begin
          rdata_next = cfg_reg.wake;
        end
      end else if (hit(bus, `GPSR_ADDR_OUT)) begin
        rdata_next = out_reg;
      end else if (hit(bus, `GPSR_ADDR_IN)) begin
        rdata_next = in_reg;
      end else if (hit(bus, `GPSR_ADDR_PORT_A_PIN_IRQ_PENDING)) begin
        rdata_next = port_a_pin_irq_pending_reg;
      end else if (hit(bus, `GPSR_ADDR_SERIAL_AND_CONVERTER_IRQ_PENDING)) begin
        rdata_next = serial_and_converter_irq_pending_reg;
      end
    end
    // polled mode keeps the flags but raises nothing
    irq_next = irq_global_en_i && ((port_a_pin_irq_pending_reg | serial_and_converter_irq_pending_reg) != 8'h00);
  end

  // registers only
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sel_reg   <= 8'h00;
      cfg_reg   <= '{dir: `GPSR_DIR_RST, alt: `GPSR_ALT_RST, wake: `GPSR_WAKE_RST};
      out_reg   <= 8'h00;
      in_reg    <= 8'h00;
      port_a_pin_irq_pending_reg  <= `GPSR_IRQ_RST;
      serial_and_converter_irq_pending_reg  <= `GPSR_IRQ_RST;
      rdata_reg <= 8'h00;
      irq_reg   <= 1'b0;
    end else begin
      sel_reg   <= sel_next;
      cfg_reg   <= cfg_next;
      out_reg   <= out_next;
      in_reg    <= in_next;
      port_a_pin_irq_pending_reg  <= port_a_pin_irq_pending_next;
      serial_and_converter_irq_pending_reg  <= serial_and_converter_irq_pending_next;
      rdata_reg <= rdata_next;
      irq_reg   <= irq_next;
    end
  end

  // pin drive: alternate first, then direction; alt_out_i and alt_oe_i reach the pins unregistered
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (cfg_reg.alt[i]) begin
        pin_o[i]    = alt_out_i[i];
        pin_oe_o[i] = alt_oe_i[i];
      end else begin
        pin_o[i]    = out_reg[i];
        pin_oe_o[i] = ~cfg_reg.dir[i];
      end
    end
  end

  assign rdata_o = rdata_reg;
  assign irq_o   = irq_reg;

  // wake detector
  gpsr_wake u_wake (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .stop_i    (stop_i),
    .wake_en_i (cfg_reg.wake),
    .pin_i     (pin_i),
    .wake_o    (wake_o)
  );

  // named steps of an indirect write
  sequence s_sel_dir;
    wr_i && addr_i == `GPSR_ADDR_SEL && wdata_i == `GPSR_SUB_DIR;
  endsequence
  sequence s_ctl_wr;
    wr_i && addr_i == `GPSR_ADDR_CTL;
  endsequence

  property p_dir_path;
    @(posedge clk_i) disable iff (rst_i)
      s_sel_dir ##1 !(wr_i && addr_i == `GPSR_ADDR_SEL) ##1 s_ctl_wr |=> cfg_reg.dir == $past(wdata_i);
  endproperty
  a_dir_path: assert property (p_dir_path) else $error("direction write lost");
  property p_sel_hold;
    @(posedge clk_i) disable iff (rst_i)
      !(wr_i && addr_i == `GPSR_ADDR_SEL) |=> $stable(sel_reg);
  endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("select changed");
  property p_alt_path;
    @(posedge clk_i) disable iff (rst_i)
      (sel_reg == `GPSR_SUB_ALT && wr_i && addr_i == `GPSR_ADDR_CTL) |=> cfg_reg.alt == $past(wdata_i);
  endproperty
  a_alt_path: assert property (p_alt_path) else $error("alternate write lost");
  property p_wake_path;
    @(posedge clk_i) disable iff (rst_i)
      (sel_reg == `GPSR_SUB_WAKE && wr_i && addr_i == `GPSR_ADDR_CTL) |=> cfg_reg.wake == $past(wdata_i);
  endproperty
  a_wake_path: assert property (p_wake_path) else $error("wake write lost");
  property p_drive;
    @(posedge clk_i) disable iff (rst_i)
      (cfg_reg.alt == 8'h00) |-> (pin_oe_o == ~cfg_reg.dir && pin_o == out_reg);
  endproperty
  a_drive: assert property (p_drive) else $error("gpio drive wrong");
  property p_alt_over;
    @(posedge clk_i) disable iff (rst_i)
      (cfg_reg.alt != 8'h00) |-> ((pin_oe_o & cfg_reg.alt) == (alt_oe_i & cfg_reg.alt) &&
                                  (pin_o & cfg_reg.alt) == (alt_out_i & cfg_reg.alt));
  endproperty
  a_alt_over: assert property (p_alt_over) else $error("alternate not in control");
  property p_irq_set;
    @(posedge clk_i) disable iff (rst_i)
      rx_irq_i |=> serial_and_converter_irq_pending_reg[`GPSR_SERIAL_AND_CONVERTER_IRQ_PENDING_RX_BIT] ##1 (irq_o || !$past(irq_global_en_i));
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("request not latched");
  property p_pin6;
    @(posedge clk_i) disable iff (rst_i)
      comp_irq_i |=> port_a_pin_irq_pending_reg[`GPSR_PIN6_BIT];
  endproperty
  a_pin6: assert property (p_pin6) else $error("comparator flag missed");
  property p_polled;
    @(posedge clk_i) disable iff (rst_i)
      !irq_global_en_i |=> !irq_o;
  endproperty
  a_polled: assert property (p_polled) else $error("irq in polled mode");
  property p_resv;
    @(posedge clk_i) disable iff (rst_i)
      1'b1 |-> serial_and_converter_irq_pending_reg[2:1] == 2'b00;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved bits set");
endmodule

//--- sim/gpsr_pin_model.sv
// model of the outside world on the eight pins of one port
// assumes ext_i is the level that an outside driver puts on pins the block has released
module gpsr_pin_model (
  // block side
  input  wire logic [7:0] pin_o_i,
  input  wire logic [7:0] pin_oe_i,
  // outside driver
  input  wire logic [7:0] ext_i,
  // resolved wire
  output logic      [7:0] level_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // per pin: the block wins while its enable is high; otherwise the outside driver sets the level
  // there is no pull, so a released pin follows the outside value, never the last driven one
  always_comb begin
    level_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & ext_i);
  end
endmodule

//--- sim/tb_gpio_port_subregs_irq.sv
// self-checking bench for the port subregister and interrupt request block
// assumes gpsr_defs.svh gives the bus addresses and the subregister select codes
`include "gpsr_defs.svh"
module tb_gpio_port_subregs_irq;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk_i = 1'b0, rst_i = 1'b1;    // clock and reset
  logic       wr = 1'b0, rd = 1'b0;          // bus strobes
  logic [11:0] addr = 12'h000;               // bus address
  logic [7:0] wdata = 8'h00, rdata, d;       // bus data
  logic [7:0] pin_in, pin_out, pin_oe;       // pin wires
  logic [7:0] ext = 8'h3C;                   // outside driver value
  logic [7:0] alt_out = 8'h00, alt_oe = 8'h00, pin_irq = 8'h00;
  logic       comp = 1'b0, rx = 1'b0, tx = 1'b0, adc = 1'b0, gen = 1'b0, stop = 1'b0;
  logic       irq, wake, seen;               // device answers and wait flag
  int         errors = 0, checks = 0;        // tallies
  // 10 MHz clock
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  gpsr_port DUT (.clk_i(clk_i), .rst_i(rst_i), .wr_i(wr), .rd_i(rd), .addr_i(addr), .wdata_i(wdata),
    .rdata_o(rdata), .pin_i(pin_in), .pin_o(pin_out), .pin_oe_o(pin_oe), .alt_out_i(alt_out),
    .alt_oe_i(alt_oe), .pin_irq_i(pin_irq), .comp_irq_i(comp), .rx_irq_i(rx), .tx_irq_i(tx),
    .adc_irq_i(adc), .irq_global_en_i(gen), .stop_i(stop), .irq_o(irq), .wake_o(wake));
  gpsr_pin_model PINS (.pin_o_i(pin_out), .pin_oe_i(pin_oe), .ext_i(ext), .level_o(pin_in));
  // strobe held for exactly one taking edge, then released right after that same edge
  task automatic bus_wr(input logic [11:0] a, input logic [7:0] v);
    @(posedge clk_i);
    wr <= 1'b1; addr <= a; wdata <= v;
    @(posedge clk_i);
    wr <= 1'b0;
    #10;
  endtask
  // read data stands for one cycle after the taking edge, so it is looked at in that cycle
  task automatic bus_rd(input logic [11:0] a, output logic [7:0] v);
    @(posedge clk_i);
    rd <= 1'b1; addr <= a;
    @(posedge clk_i);
    rd <= 1'b0;
    #10 v = rdata;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // select a subregister, then read it back through the control address
  task automatic sub_chk(input logic [7:0] code, input logic [7:0] exp);
    bus_wr(`GPSR_ADDR_SEL, code);
    bus_rd(`GPSR_ADDR_CTL, d);
    chk(d, exp);
  endtask
  // reset values of every subregister and the port pending latch, pins released
  task automatic t_reset;
    chk(pin_oe, 8'h00);
    sub_chk(`GPSR_SUB_DIR, 8'hFF);
    sub_chk(`GPSR_SUB_ALT, 8'h00);
    sub_chk(`GPSR_SUB_WAKE, 8'h00);
    bus_rd(`GPSR_ADDR_PORT_A_PIN_IRQ_PENDING, d); chk(d, 8'h00);
    bus_rd(12'h000, d); chk(d, 8'h00);        // unmapped place reads zero
  endtask
  // low nibble made outputs, high nibble sampled from outside
  task automatic t_dir;
    bus_wr(`GPSR_ADDR_SEL, `GPSR_SUB_DIR);
    bus_wr(`GPSR_ADDR_CTL, 8'hF0);
    chk(pin_oe, 8'h0F);
    bus_wr(`GPSR_ADDR_OUT, 8'hA5);
    chk(pin_out & 8'h0F, 8'h05);
    bus_rd(`GPSR_ADDR_CTL, d); chk(d, 8'hF0);
    bus_rd(`GPSR_ADDR_IN, d); chk(d & 8'hF0, 8'h30);
  endtask
  // alternate side takes pin 0 over from the output data, whatever its direction bit says
  task automatic t_alt;
    @(posedge clk_i);
    alt_oe <= 8'h01;
    sub_chk(8'h03, 8'h00);                    // unknown select code reads back zero
    bus_wr(`GPSR_ADDR_SEL, `GPSR_SUB_ALT);
    bus_wr(`GPSR_ADDR_CTL, 8'h01);
    chk(pin_oe, 8'h0F); chk(pin_out & 8'h01, 8'h00);
    @(posedge clk_i); alt_oe <= 8'h00; #10;
    chk(pin_oe, 8'h0E);
    sub_chk(`GPSR_SUB_ALT, 8'h01);
    bus_wr(`GPSR_ADDR_CTL, 8'h00);
    chk(pin_oe, 8'h0F); chk(pin_out & 8'h01, 8'h01);
  endtask
  task automatic wait_wake;
    seen = 1'b0;
    repeat (4) begin
      @(posedge clk_i); #10;
      if (wake === 1'b1) seen = 1'b1;
    end
  endtask
  // only the pin enabled as wake source brings the device out of stop
  task automatic t_wake;
    sub_chk(`GPSR_SUB_DIR, 8'hF0);
    bus_wr(`GPSR_ADDR_CTL, 8'hFF);
    bus_wr(`GPSR_ADDR_SEL, `GPSR_SUB_WAKE);
    bus_wr(`GPSR_ADDR_CTL, 8'h01);
    @(posedge clk_i); stop <= 1'b1;
    @(posedge clk_i); ext <= ext ^ 8'h02;     // disabled pin toggles
    wait_wake(); chk({7'h00, seen}, 8'h00);
    @(posedge clk_i); ext <= ext ^ 8'h01;     // enabled pin rises
    wait_wake(); chk({7'h00, seen}, 8'h01);
    @(posedge clk_i); ext <= ext ^ 8'h01;     // and falls
    wait_wake(); chk({7'h00, seen}, 8'h01);
    @(posedge clk_i); stop <= 1'b0; ext <= ext ^ 8'h01;
    wait_wake(); chk({7'h00, seen}, 8'h00);
  endtask
  // every source but pin 6, whose bit the comparator sets, sets its own latch; forwarding follows the global enable
  task automatic t_irq;
    @(posedge clk_i);
    pin_irq <= 8'hBF; comp <= 1'b1; rx <= 1'b1; tx <= 1'b1; adc <= 1'b1;
    @(posedge clk_i);
    pin_irq <= 8'h00; comp <= 1'b0; rx <= 1'b0; tx <= 1'b0; adc <= 1'b0;
    repeat (3) @(posedge clk_i); #10;
    chk({7'h00, irq}, 8'h00);
    bus_rd(`GPSR_ADDR_PORT_A_PIN_IRQ_PENDING, d); chk(d, 8'hFF);
    bus_rd(`GPSR_ADDR_SERIAL_AND_CONVERTER_IRQ_PENDING, d); chk(d, 8'h19);
    @(posedge clk_i); gen <= 1'b1;
    repeat (3) @(posedge clk_i); #10;
    chk({7'h00, irq}, 8'h01);
    bus_wr(`GPSR_ADDR_PORT_A_PIN_IRQ_PENDING, 8'h00);
    bus_wr(`GPSR_ADDR_SERIAL_AND_CONVERTER_IRQ_PENDING, 8'h00);
    repeat (3) @(posedge clk_i); #10;
    chk({7'h00, irq}, 8'h00);
    bus_rd(`GPSR_ADDR_SERIAL_AND_CONVERTER_IRQ_PENDING, d); chk(d, 8'h00);
  endtask
  task automatic report_and_stop;
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_dir();
    t_alt();
    t_wake();
    t_irq();
    report_and_stop();
  end
  // watchdog: the whole sequence needs about 110 cycles, far below the 4000-cycle limit
  initial begin
    #400000;
    errors++;
    report_and_stop();
  end
endmodule
